// [logic/wpsd_demod_top.sv]
/*
 Walsh phase switch demodulator for one baseline: sequencer, sample
 fifo, sign demodulation, two state bins and sideband recovery.
 Assumes phase mode is held steady across a dump and samples arrive
 LAT cycles after the oscillator phase that produced them.
*/
`default_nettype none
`include "wpsd_regs.svh"
module wpsd_demod_top
   import wpsd_pkg::*;
#(
   parameter int SW = 4,
   parameter int AW = 32,
   parameter int CW = 8,
   parameter int DEPTH = `WPSD_FIFO_DEPTH,
   parameter int STEP_CYC = `WPSD_STEP_CYC,
   parameter int LAT = `WPSD_LO_LAT,
   parameter int IDW = $clog2(`WPSD_STEPS)
)(
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic [1:0] i_mode,
   input wire logic [IDW-1:0] i_ant1_id,
   input wire logic [IDW-1:0] i_ant2_id,
   input wire logic [CW-1:0] i_dump_cycles,
   input wire logic i_in_valid,
   input wire logic signed [SW-1:0] i_a1_re,
   input wire logic signed [SW-1:0] i_a1_im,
   input wire logic signed [SW-1:0] i_a2_re,
   input wire logic signed [SW-1:0] i_a2_im,
   output logic o_in_ready,
   output logic [1:0] o_lo_phase1,
   output logic [1:0] o_lo_phase2,
   input wire logic i_vis_ready,
   output logic o_vis_valid,
   output logic o_vis_auto,
   output logic signed [AW-1:0] o_usb_re,
   output logic signed [AW-1:0] o_usb_im,
   output logic signed [AW-1:0] o_lsb_re,
   output logic signed [AW-1:0] o_lsb_im
);
   localparam int DW = SW + 1;
   localparam int PW = 2 * DW + 1;
   localparam int TW = 3 + 4 * SW;

   // widen first so the most negative sample negates cleanly
   function automatic logic signed [DW-1:0] flip(input logic signed [SW-1:0] x, input logic f);
      return f ? -DW'(x) : DW'(x);
   endfunction

   logic [2:0] tag;
   wpsd_strm_if #(.W(TW)) in_if ();
   wpsd_strm_if #(.W(TW)) out_if ();

   wpsd_walsh_seq #(
      .STEP_CYC(STEP_CYC),
      .LAT(LAT),
      .IDW(IDW)
   ) u_seq (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_mode(i_mode),
      .i_ant1_id(i_ant1_id),
      .i_ant2_id(i_ant2_id),
      .o_lo_phase1(o_lo_phase1),
      .o_lo_phase2(o_lo_phase2),
      .o_tag(tag)
   );

   // the digitizer holds a refused sample, so it keeps the tag of the
   // cycle in which it was first offered
   logic [2:0] etag, tag_q, tag_d;
   logic held_q, held_d;

   always_comb begin
      etag = held_q ? tag_q : tag;
      tag_d = etag;
      held_d = i_in_valid && !in_if.ready;
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         tag_q <= '0;
         held_q <= 1'b0;
      end else begin
         tag_q <= tag_d;
         held_q <= held_d;
      end
   end

   // tag joins the sample on entry so fifo stalls cannot skew it
   assign in_if.valid = i_in_valid;
   assign in_if.data = {etag, i_a1_re, i_a1_im, i_a2_re, i_a2_im};
   assign o_in_ready = in_if.ready;

   wpsd_fifo #(
      .W(TW),
      .DEPTH(DEPTH)
   ) u_fifo (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .wr(in_if.snk),
      .rd(out_if.src)
   );

   logic par, w1, w2, pop, auto_p, dem, bin, boundary, dump;
   logic signed [SW-1:0] a1re, a1im, a2re, a2im;
   logic signed [DW-1:0] d1re, d1im, d2re, d2im;
   logic signed [PW-1:0] p_re, p_im;
   logic signed [AW-1:0] rot_re, rot_im;
   logic signed [AW:0] s_re, s_im, t_re, t_im;
   logic signed [AW-1:0] acc_re_q [2];
   logic signed [AW-1:0] acc_im_q [2];
   logic signed [AW-1:0] acc_re_d [2];
   logic signed [AW-1:0] acc_im_d [2];
   logic [CW-1:0] cnt_q, cnt_d;
   logic par_seen_q, par_seen_d, sync_q, sync_d;
   logic vis_valid_q, vis_valid_d, vauto_q, vauto_d;
   logic signed [AW-1:0] usb_re_q, usb_im_q, lsb_re_q, lsb_im_q;
   logic signed [AW-1:0] usb_re_d, usb_im_d, lsb_re_d, lsb_im_d;
   wpsd_mode_e mode, vmode_q, vmode_d;

   assign {par, w1, w2, a1re, a1im, a2re, a2im} = out_if.data;
   // a held visibility blocks the drain, which backs the fifo up
   assign out_if.ready = !vis_valid_q || i_vis_ready;

   always_comb begin
      mode = wpsd_mode_e'(i_mode);
      pop = out_if.valid && out_if.ready;
      auto_p = (i_ant1_id == i_ant2_id);
      dem = (mode == WPSD_M180) && !auto_p;
      d1re = flip(a1re, dem && w1);
      d1im = flip(a1im, dem && w1);
      d2re = flip(a2re, dem && w2);
      d2im = flip(a2im, dem && w2);
      // product of antenna 1 with the conjugate of antenna 2
      p_re = PW'(d1re * d2re) + PW'(d1im * d2im);
      p_im = PW'(d1im * d2re) - PW'(d1re * d2im);
      bin = (mode == WPSD_M90) && !auto_p && w2;
      boundary = pop && (par != par_seen_q);
      dump = boundary && sync_q && (CW'(cnt_q + 1'b1) >= i_dump_cycles);
      par_seen_d = pop ? par : par_seen_q;
      sync_d = sync_q || boundary;
      cnt_d = cnt_q;
      if (boundary) begin
         cnt_d = (dump || !sync_q) ? '0 : CW'(cnt_q + 1'b1);
      end
      acc_re_d = acc_re_q;
      acc_im_d = acc_im_q;
      // first partial cycle is thrown away; bins restart on each dump
      if (boundary && (dump || !sync_q)) begin
         acc_re_d[0] = '0;
         acc_im_d[0] = '0;
         acc_re_d[1] = '0;
         acc_im_d[1] = '0;
      end
      if (pop && sync_d) begin
         acc_re_d[bin] = acc_re_d[bin] + AW'(p_re);
         acc_im_d[bin] = acc_im_d[bin] + AW'(p_im);
      end
      // quarter turn back: (re, im) of state 1 becomes (im, -re)
      rot_re = acc_im_q[1];
      rot_im = -acc_re_q[1];
      s_re = (AW+1)'(acc_re_q[0]) + (AW+1)'(rot_re);
      s_im = (AW+1)'(acc_im_q[0]) + (AW+1)'(rot_im);
      t_re = (AW+1)'(acc_re_q[0]) - (AW+1)'(rot_re);
      t_im = (AW+1)'(acc_im_q[0]) - (AW+1)'(rot_im);
      vis_valid_d = (vis_valid_q && !i_vis_ready) || dump;
      vmode_d = vmode_q;
      vauto_d = vauto_q;
      usb_re_d = usb_re_q;
      usb_im_d = usb_im_q;
      lsb_re_d = lsb_re_q;
      lsb_im_d = lsb_im_q;
      if (dump) begin
         vmode_d = mode;
         vauto_d = auto_p;
         if (mode == WPSD_M90 && !auto_p) begin
            usb_re_d = s_re[AW:1];
            usb_im_d = s_im[AW:1];
            lsb_re_d = t_re[AW:1];
            lsb_im_d = t_im[AW:1];
         end else begin
            usb_re_d = acc_re_q[0];
            usb_im_d = acc_im_q[0];
            lsb_re_d = '0;
            lsb_im_d = '0;
         end
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         for (int i = 0; i < 2; i++) begin
            acc_re_q[i] <= '0;
            acc_im_q[i] <= '0;
         end
         cnt_q <= '0;
         par_seen_q <= 1'b0;
         sync_q <= 1'b0;
         vis_valid_q <= 1'b0;
         vauto_q <= 1'b0;
         vmode_q <= WPSD_OFF;
         usb_re_q <= '0;
         usb_im_q <= '0;
         lsb_re_q <= '0;
         lsb_im_q <= '0;
      end else begin
         acc_re_q <= acc_re_d;
         acc_im_q <= acc_im_d;
         cnt_q <= cnt_d;
         par_seen_q <= par_seen_d;
         sync_q <= sync_d;
         vis_valid_q <= vis_valid_d;
         vauto_q <= vauto_d;
         vmode_q <= vmode_d;
         usb_re_q <= usb_re_d;
         usb_im_q <= usb_im_d;
         lsb_re_q <= lsb_re_d;
         lsb_im_q <= lsb_im_d;
      end
   end

   assign o_vis_valid = vis_valid_q;
   assign o_vis_auto = vauto_q;
   assign o_usb_re = usb_re_q;
   assign o_usb_im = usb_im_q;
   assign o_lsb_re = lsb_re_q;
   assign o_lsb_im = lsb_im_q;

   property p_flip180;
      @(posedge i_clock) disable iff (!i_resetn)
      (pop && mode == WPSD_M180 && !auto_p && w2) |-> ((d2re + DW'(a2re)) == '0);
   endproperty
   a_flip180: assert property (p_flip180) else $error("half turn not removed");
   property p_auto;
      @(posedge i_clock) disable iff (!i_resetn)
      (pop && auto_p) |-> (d1re == DW'(a1re)) && (d2re == DW'(a2re)) && !bin;
   endproperty
   a_auto: assert property (p_auto) else $error("auto product was demodulated");
   property p_bins;
      @(posedge i_clock) disable iff (!i_resetn)
      (pop && sync_q && !boundary && bin) |=> $stable(acc_re_q[0]) && $stable(acc_im_q[0]);
   endproperty
   a_bins: assert property (p_bins) else $error("state 1 leaked into bin 0");
   property p_sum180;
      @(posedge i_clock) disable iff (!i_resetn)
      (o_vis_valid && vmode_q != WPSD_M90) |-> (o_lsb_re == '0) && (o_lsb_im == '0);
   endproperty
   a_sum180: assert property (p_sum180) else $error("single bin dump has lower part");

   property p_swap;
      @(posedge i_clock) disable iff (!i_resetn)
      (dump && mode == WPSD_M90 && !auto_p)
         |=> o_vis_valid && (o_usb_re == AW'(((AW+1)'($past(acc_re_q[0]))
            + (AW+1)'($past(acc_im_q[1]))) >>> 1));
   endproperty
   a_swap: assert property (p_swap) else $error("state 1 parts not exchanged");

   property p_lsb_sign;
      @(posedge i_clock) disable iff (!i_resetn)
      (dump && mode == WPSD_M90 && !auto_p && acc_re_q[1] == '0 && acc_im_q[1] == '0)
         |=> (o_usb_re == o_lsb_re) && (o_usb_im == o_lsb_im);
   endproperty
   a_lsb_sign: assert property (p_lsb_sign) else $error("sideband split wrong");

   property p_hold;
      @(posedge i_clock) disable iff (!i_resetn)
      (o_vis_valid && !i_vis_ready) |=> o_vis_valid && $stable(o_usb_re) && $stable(o_lsb_im);
   endproperty
   a_hold: assert property (p_hold) else $error("visibility dropped while stalled");

   property p_vis_take;
      @(posedge i_clock) disable iff (!i_resetn)
      (o_vis_valid && i_vis_ready && !dump) |=> !o_vis_valid;
   endproperty
   a_vis_take: assert property (p_vis_take) else $error("visibility not released");

   property p_tag_hold;
      @(posedge i_clock) disable iff (!i_resetn)
      (i_in_valid && !o_in_ready) |=> (etag == $past(etag));
   endproperty
   a_tag_hold: assert property (p_tag_hold) else $error("held sample lost its tag");

   property p_discard;
      @(posedge i_clock) disable iff (!i_resetn)
      (pop && !sync_d) |=> (acc_re_q[0] == '0) && (acc_re_q[1] == '0);
   endproperty
   a_discard: assert property (p_discard) else $error("partial cycle accumulated");

   property p_count;
      @(posedge i_clock) disable iff (!i_resetn)
      (boundary && sync_q && !dump) |=> (cnt_q == CW'($past(cnt_q) + 1'b1));
   endproperty
   a_count: assert property (p_count) else $error("walsh cycle count slipped");
endmodule // wpsd_demod_top
`default_nettype wire

// [logic/wpsd_regs.svh]
/*
 Timing and code constants for the walsh phase switch demodulator.
 Assumes a 20 MHz core clock; included by bare name.
*/
`ifndef WPSD_REGS_SVH
`define WPSD_REGS_SVH
// walsh step 16 ms, full cycle 2048 ms
`define WPSD_STEP_MS 32'h10
`define WPSD_CYCLE_MS 32'h800
// core clock in kHz (20 MHz)
`define WPSD_CLK_KHZ 32'h4E20
`define WPSD_STEP_CYC (`WPSD_STEP_MS * `WPSD_CLK_KHZ)
`define WPSD_STEPS (`WPSD_CYCLE_MS / `WPSD_STEP_MS)
// cycles from oscillator phase change to the affected sample
`define WPSD_LO_LAT 32'h2
`define WPSD_FIFO_DEPTH 32'h20
`define WPSD_PH_0 2'h0
`define WPSD_PH_90 2'h1
`define WPSD_PH_180 2'h2
`endif

// [logic/wpsd_pkg.sv]
/*
 Types shared by the walsh phase switch demodulator modules.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package wpsd_pkg;
   typedef enum logic [1:0] {
      WPSD_OFF = 2'b00,
      WPSD_M180 = 2'b01,
      WPSD_M90 = 2'b10
   } wpsd_mode_e;
   typedef logic [1:0] wpsd_phase_t;
endpackage
`default_nettype wire

// [logic/wpsd_strm_if.sv]
/*
 Valid/ready stream carrier between the demodulator and its fifo.
 Assumes both ends share one clock.
*/
`default_nettype none
interface wpsd_strm_if #(parameter int W = 8);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// [logic/wpsd_fifo.sv]
/*
 Flop based fifo with valid/ready on both sides.
 Assumes one clock; ready toward the writer comes from a flop.
*/
`default_nettype none
`include "wpsd_regs.svh"
module wpsd_fifo #(
   parameter int W = 8,
   parameter int DEPTH = `WPSD_FIFO_DEPTH,
   parameter int PW = $clog2(DEPTH)
)(
   input wire logic i_clock,
   input wire logic i_resetn,
   wpsd_strm_if.snk wr,
   wpsd_strm_if.src rd
);
   function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
      return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
   endfunction
   logic [W-1:0] mem_q [DEPTH];
   logic [W-1:0] mem_d [DEPTH];
   logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [PW:0] cnt_q, cnt_d;
   logic rdy_q, rdy_d;
   logic push, pop;
   always_comb begin
      push = wr.valid && rdy_q;
      pop = rd.valid && rd.ready;
      mem_d = mem_q;
      if (push) begin
         mem_d[wp_q] = wr.data;
      end
      wp_d = push ? nxt(wp_q) : wp_q;
      rp_d = pop ? nxt(rp_q) : rp_q;
      cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
      // registered ready taken from the next count: all DEPTH slots fill, none is lost
      rdy_d = (cnt_d != (PW+1)'(DEPTH));
   end
   always_ff @(posedge i_clock) begin
      mem_q <= mem_d;
   end
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         rdy_q <= 1'b0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
         rdy_q <= rdy_d;
      end
   end
   assign wr.ready = rdy_q;
   assign rd.valid = (cnt_q != '0);
   assign rd.data = mem_q[rp_q];
endmodule // wpsd_fifo
`default_nettype wire

// [logic/wpsd_walsh_seq.sv]
/*
 Walsh pattern sequencer: steps the pattern index, drives oscillator
 phase codes and a tag delayed to line up with returning samples.
 Assumes antenna ids are distinct across the array.
*/
`default_nettype none
`include "wpsd_regs.svh"
module wpsd_walsh_seq
   import wpsd_pkg::*;
#(
   parameter int STEP_CYC = `WPSD_STEP_CYC,
   parameter int STEPS = `WPSD_STEPS,
   parameter int LAT = `WPSD_LO_LAT,
   parameter int IDW = $clog2(STEPS)
)(
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic [1:0] i_mode,
   input wire logic [IDW-1:0] i_ant1_id,
   input wire logic [IDW-1:0] i_ant2_id,
   output logic [1:0] o_lo_phase1,
   output logic [1:0] o_lo_phase2,
   output logic [2:0] o_tag
);
   localparam int DW = $clog2(STEP_CYC);
   // hadamard row: distinct ids give orthogonal rows over STEPS steps
   function automatic logic walsh_bit(input logic [IDW-1:0] id, input logic [IDW-1:0] ix);
      return ^(id & ix);
   endfunction
   logic [DW-1:0] div_q, div_d;
   logic [IDW-1:0] idx_q, idx_d;
   logic par_q, par_d, wrap, w1, w2;
   wpsd_phase_t ph1_q, ph1_d, ph2_q, ph2_d;
   logic [2:0] tap_q [LAT+1];
   logic [2:0] tap_d [LAT+1];
   always_comb begin
      wrap = (div_q == DW'(STEP_CYC - 1));
      div_d = wrap ? '0 : DW'(div_q + 1'b1);
      idx_d = wrap ? IDW'(idx_q + 1'b1) : idx_q;
      par_d = (wrap && idx_q == IDW'(STEPS - 1)) ? ~par_q : par_q;
      w1 = walsh_bit(i_ant1_id, idx_q);
      w2 = walsh_bit(i_ant2_id, idx_q);
      ph1_d = `WPSD_PH_0;
      ph2_d = `WPSD_PH_0;
      unique case (wpsd_mode_e'(i_mode))
         WPSD_OFF: begin
         end
         WPSD_M180: begin
            ph1_d = w1 ? `WPSD_PH_180 : `WPSD_PH_0;
            ph2_d = w2 ? `WPSD_PH_180 : `WPSD_PH_0;
         end
         WPSD_M90: begin
            ph2_d = w2 ? `WPSD_PH_90 : `WPSD_PH_0;
         end
         default: begin
         end
      endcase
      // tap 0 changes with the phase outputs; tap LAT meets the samples
      tap_d[0] = {par_q, w1, w2};
      for (int i = 1; i <= LAT; i++) begin
         tap_d[i] = tap_q[i-1];
      end
   end
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         div_q <= '0;
         idx_q <= '0;
         par_q <= 1'b0;
         ph1_q <= `WPSD_PH_0;
         ph2_q <= `WPSD_PH_0;
         for (int i = 0; i <= LAT; i++) begin
            tap_q[i] <= '0;
         end
      end else begin
         div_q <= div_d;
         idx_q <= idx_d;
         par_q <= par_d;
         ph1_q <= ph1_d;
         ph2_q <= ph2_d;
         tap_q <= tap_d;
      end
   end
   assign o_lo_phase1 = ph1_q;
   assign o_lo_phase2 = ph2_q;
   assign o_tag = tap_q[LAT];

   property p_step;
      @(posedge i_clock) disable iff (!i_resetn)
      (div_q == DW'(STEP_CYC - 1)) |=> (idx_q == IDW'($past(idx_q) + 1'b1));
   endproperty
   a_step: assert property (p_step) else $error("walsh index did not step");
   property p_steady;
      @(posedge i_clock) disable iff (!i_resetn)
      (div_q != DW'(STEP_CYC - 1)) |=> $stable(idx_q);
   endproperty
   a_steady: assert property (p_steady) else $error("walsh index moved mid step");
   property p_cycle;
      @(posedge i_clock) disable iff (!i_resetn)
      (wrap && idx_q == IDW'(STEPS - 1)) |=> (par_q != $past(par_q)) && (idx_q == '0);
   endproperty
   a_cycle: assert property (p_cycle) else $error("walsh cycle end missed");
   property p_lo90;
      @(posedge i_clock) disable iff (!i_resetn)
      (i_mode == WPSD_M90) |=> (o_lo_phase1 == `WPSD_PH_0)
         && (o_lo_phase2 == ($past(w2) ? `WPSD_PH_90 : `WPSD_PH_0));
   endproperty
   a_lo90: assert property (p_lo90) else $error("quarter turn phase wrong");
   property p_align;
      @(posedge i_clock) disable iff (!i_resetn)
      o_tag == $past(tap_q[0], LAT);
   endproperty
   a_align: assert property (p_align) else $error("sample tag misaligned");
endmodule // wpsd_walsh_seq
`default_nettype wire

// [test/wpsd_far_model.sv]
/*
 Far side model: two digitizers fed through the oscillator phase codes.
 Assumes a sample leaves two cycles after the phase that produced it.
*/
`default_nettype none
module wpsd_far_model (
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic i_quarter,
   input wire logic [1:0] i_lo_phase1,
   input wire logic [1:0] i_lo_phase2,
   input wire logic i_ready,
   output logic o_valid,
   output logic signed [3:0] o_a1_re,
   output logic signed [3:0] o_a1_im,
   output logic signed [3:0] o_a2_re,
   output logic signed [3:0] o_a2_im
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [1:0][1:0] h1, h2;
   logic alt;
   logic hold;
   int sg;

   // turn (re,im) by k quarter turns
   function automatic int qr(input int re, input int im, input int k, input bit want_im);
      int r;
      int i;
      case (k & 3)
         0: begin r = re; i = im; end
         1: begin r = -im; i = re; end
         2: begin r = -re; i = -im; end
         default: begin r = im; i = -re; end
      endcase
      return want_im ? i : r;
   endfunction

   // upper sideband turns against the phase, lower with it; spur is not switched
   function automatic int smp(input int ur, input int ui, input int lr, input int li,
                              input int n, input int ph, input int s, input bit im);
      return qr(ur, ui, 4 - ph, im) + s * qr(lr, li, ph, im) + n;
   endfunction

   always @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         h1 <= '0;
         h2 <= '0;
      end else begin
         h1 <= {h1[0], i_lo_phase1};
         h2 <= {h2[0], i_lo_phase2};
      end
   end

   initial begin
      o_valid = 1'b0;
      alt = 1'b0;
      {o_a1_re, o_a1_im, o_a2_re, o_a2_im} = '0;
      forever begin
         @(posedge i_clock);
         hold = o_valid && !i_ready;
         #2;
         if (!i_resetn) begin
            o_valid = 1'b0;
         end else if (!hold) begin
            // lower sideband alternates so its cross terms cancel in pairs
            alt = ~alt;
            sg = alt ? 1 : -1;
            o_valid = 1'b1;
            if (i_quarter) begin
               o_a1_re = 4'(smp(2, 0, 0, 1, 0, int'(h1[1]), sg, 0));
               o_a1_im = 4'(smp(2, 0, 0, 1, 0, int'(h1[1]), sg, 1));
               o_a2_re = 4'(smp(1, 1, 1, 0, 0, int'(h2[1]), sg, 0));
               o_a2_im = 4'(smp(1, 1, 1, 0, 0, int'(h2[1]), sg, 1));
            end else begin
               o_a1_re = 4'(smp(2, 1, 0, 0, 1, int'(h1[1]), sg, 0));
               o_a1_im = 4'(smp(2, 1, 0, 0, 1, int'(h1[1]), sg, 1));
               o_a2_re = 4'(smp(2, -1, 0, 0, 1, int'(h2[1]), sg, 0));
               o_a2_im = 4'(smp(2, -1, 0, 0, 1, int'(h2[1]), sg, 1));
            end
         end
      end
   end
endmodule // wpsd_far_model
`default_nettype wire

// [test/tb_top.sv]
/*
 Self-checking bench for the walsh phase switch demodulator top.
 Assumes a walsh step shortened to 4 cycles so whole cycles fit a run.
*/
`default_nettype none
module tb_top
   import wpsd_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int STEP = 4;
   logic i_clock, i_resetn, i_in_valid, o_in_ready, i_vis_ready, o_vis_valid, o_vis_auto;
   logic [1:0] i_mode, o_lo_phase1, o_lo_phase2;
   logic [6:0] i_ant1_id, i_ant2_id;
   logic [7:0] i_dump_cycles;
   logic signed [3:0] a1r, a1i, a2r, a2i;
   logic signed [31:0] o_usb_re, o_usb_im, o_lsb_re, o_lsb_im;
   int fails, total_checks, bad_ph, g;

   wpsd_demod_top #(.STEP_CYC(STEP)) i_wpsd_demod_top (
      .i_clock(i_clock), .i_resetn(i_resetn), .i_mode(i_mode),
      .i_ant1_id(i_ant1_id), .i_ant2_id(i_ant2_id), .i_dump_cycles(i_dump_cycles),
      .i_in_valid(i_in_valid), .i_a1_re(a1r), .i_a1_im(a1i), .i_a2_re(a2r),
      .i_a2_im(a2i), .o_in_ready(o_in_ready), .o_lo_phase1(o_lo_phase1),
      .o_lo_phase2(o_lo_phase2), .i_vis_ready(i_vis_ready), .o_vis_valid(o_vis_valid),
      .o_vis_auto(o_vis_auto), .o_usb_re(o_usb_re), .o_usb_im(o_usb_im),
      .o_lsb_re(o_lsb_re), .o_lsb_im(o_lsb_im));

   wpsd_far_model i_wpsd_far_model (
      .i_clock(i_clock), .i_resetn(i_resetn), .i_quarter(i_mode == WPSD_M90),
      .i_lo_phase1(o_lo_phase1), .i_lo_phase2(o_lo_phase2), .i_ready(o_in_ready),
      .o_valid(i_in_valid), .o_a1_re(a1r), .o_a1_im(a1i), .o_a2_re(a2r), .o_a2_im(a2i));

   always #25 i_clock = ~i_clock;

   // codes that the active mode must never show
   always @(posedge i_clock) begin
      if (i_resetn && i_mode == WPSD_M90 && (o_lo_phase1 !== 2'h0 || o_lo_phase2 === 2'h2))
         bad_ph++;
      if (i_resetn && i_mode == WPSD_M180 && (o_lo_phase1 === 2'h1 || o_lo_phase2 === 2'h1))
         bad_ph++;
   end

   task automatic step(input int n = 1);
      repeat (n) @(posedge i_clock);
      #2;
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_flag(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic summarize();
      $display("checks=%0d mismatches=%0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic give_up();
      chk_flag(1'b0, 1'b1);
      summarize();
   endtask

   task automatic start(input logic [1:0] md, input logic [6:0] id1, input logic [6:0] id2,
                        input logic [7:0] dc);
      i_mode = md;
      i_ant1_id = id1;
      i_ant2_id = id2;
      i_dump_cycles = dc;
      i_vis_ready = 1'b0;
      i_resetn = 1'b0;
      step(20);
      chk_flag(o_in_ready, 1'b0);
      chk_flag(o_vis_valid, 1'b0);
      i_resetn = 1'b1;
      step();
      chk_flag(o_in_ready, 1'b1);
      bad_ph = 0;
   endtask

   task automatic wait_vis();
      int n;
      n = 0;
      while (o_vis_valid !== 1'b1) begin
         if (n == 3000)
            give_up();
         n++;
         step();
      end
   endtask

   task automatic expect_vis(input int ur, input int ui, input int lr, input int li,
                             input logic au);
      wait_vis();
      chk_word(o_usb_re, ur);
      chk_word(o_usb_im, ui);
      chk_word(o_lsb_re, lr);
      chk_word(o_lsb_im, li);
      chk_flag(o_vis_auto, au);
      i_vis_ready = 1'b1;
      step();
      i_vis_ready = 1'b0;
      chk_flag(o_vis_valid, 1'b0);
   endtask

   // cycles between two changes of the second antenna's phase
   task automatic gap_of(output int gap);
      logic [1:0] p;
      int n;
      n = 0;
      p = o_lo_phase2;
      while (o_lo_phase2 === p) begin
         if (n == 2000)
            give_up();
         n++;
         step();
      end
      p = o_lo_phase2;
      gap = 0;
      while (o_lo_phase2 === p) begin
         if (gap == 2000)
            give_up();
         gap++;
         step();
      end
   endtask

   task automatic test_half();
      start(WPSD_M180, 7'h03, 7'h05, 8'h02);
      expect_vis(3072, 4096, 0, 0, 1'b0);
      expect_vis(3072, 4096, 0, 0, 1'b0);
      chk_word(bad_ph, 0);
      $display("test_half done");
   endtask

   task automatic test_quarter();
      start(WPSD_M90, 7'h06, 7'h05, 8'h01);
      expect_vis(512, -512, 0, 256, 1'b0);
      chk_word(bad_ph, 0);
      // second antenna never shifted: state 1 bin stays empty, sidebands equal
      start(WPSD_M90, 7'h06, 7'h00, 8'h01);
      expect_vis(512, -256, 512, -256, 1'b0);
      chk_word(bad_ph, 0);
      $display("test_quarter done");
   endtask

   task automatic test_auto();
      start(WPSD_M180, 7'h05, 7'h05, 8'h01);
      expect_vis(2560, 2048, 0, 0, 1'b1);
      $display("test_auto done");
   endtask

   task automatic test_off();
      start(WPSD_OFF, 7'h03, 7'h05, 8'h00);
      expect_vis(4608, 3072, 0, 0, 1'b0);
      start(2'h3, 7'h03, 7'h05, 8'h00);
      expect_vis(4608, 3072, 0, 0, 1'b0);
      $display("test_off done");
   endtask

   task automatic test_step();
      start(WPSD_M180, 7'h00, 7'h01, 8'h01);
      gap_of(g);
      chk_word(g, STEP);
      start(WPSD_M180, 7'h00, 7'h40, 8'h01);
      gap_of(g);
      chk_word(g, 64 * STEP);
      $display("test_step done");
   endtask

   // visibility left untaken: fifo must fill, refuse, and hold the result
   task automatic test_fill();
      int n;
      start(WPSD_M180, 7'h03, 7'h05, 8'h01);
      wait_vis();
      n = 0;
      while (o_in_ready !== 1'b0) begin
         if (n == 60)
            give_up();
         n++;
         step();
      end
      step(10);
      chk_flag(o_in_ready, 1'b0);
      chk_flag(o_vis_valid, 1'b1);
      chk_word(o_usb_re, 1536);
      chk_word(o_usb_im, 2048);
      i_vis_ready = 1'b1;
      step();
      i_vis_ready = 1'b0;
      step(4);
      chk_flag(o_in_ready, 1'b1);
      $display("test_fill done");
   endtask

   initial begin
      i_clock = 1'b0;
      i_resetn = 1'b0;
      i_mode = 2'h0;
      i_ant1_id = 7'h00;
      i_ant2_id = 7'h00;
      i_dump_cycles = 8'h01;
      i_vis_ready = 1'b0;
      fails = 0;
      total_checks = 0;
      bad_ph = 0;
      test_half();
      test_quarter();
      test_auto();
      test_off();
      test_step();
      test_fill();
      summarize();
   end
endmodule // tb_top
`default_nettype wire
